// [rtl/ddc_regs.vh]
`ifndef DDC_REGS_VH
`define DDC_REGS_VH

// register offsets
`define DDC_CONTROL_ADDR     12'h0330
`define DDC_ROUTE_ADDR       12'h0331
`define DDC_TUNE_LOW_ADDR    12'h0334
`define DDC_TUNE_HIGH_ADDR   12'h0335
`define DDC_PHASE_LOW_ADDR   12'h0340
`define DDC_PHASE_HIGH_ADDR  12'h0341

// reset value for control, route and both low-byte registers
`define DDC_REG_RESET        8'h00

// control field positions
`define DDC_CTL_MIXER_BIT    7
`define DDC_CTL_GAIN_BIT     6
`define DDC_CTL_IF_HI        5
`define DDC_CTL_IF_LO        4
`define DDC_CTL_C2R_BIT      3
`define DDC_CTL_DEC_HI       1
`define DDC_CTL_DEC_LO       0

// writable bit masks; masked bits read as zero
`define DDC_CTL_MASK         8'hFB
`define DDC_ROUTE_MASK       8'h05
`define DDC_HIGH_MASK        8'h0F

// route field positions
`define DDC_ROUTE_Q_BIT      2
`define DDC_ROUTE_I_BIT      0

// intermediate frequency modes
`define DDC_IF_VARIABLE      2'h0
`define DDC_IF_ZERO          2'h1
`define DDC_IF_QUARTER       2'h2
`define DDC_IF_TEST          2'h3

// decimation select codes
`define DDC_DEC_BY_TWO       2'h2

// sample width, positive full scale
`define DDC_SAMPLE_W         12
`define DDC_FULL_SCALE       12'h7FF
`define DDC_NEG_SCALE        12'h800

// buffer word holds i in high half, q in low half
`define DDC_WORD_W           24

`endif

// [rtl/ddc_buffer.v]
`timescale 1ns/100ps
`include "ddc_regs.vh"

module ddc_buffer (
    // clock and control
    input  wire                      i_clock,
    input  wire                      i_reset,
    input  wire                      i_clock_enable,
    // filling side
    input  wire                      i_push_valid,
    input  wire [`DDC_WORD_W-1:0]    i_push_data,
    output wire                      o_push_ready,
    // draining side
    output wire                      o_pop_valid,
    output wire [`DDC_WORD_W-1:0]    o_pop_data,
    input  wire                      i_pop_ready
);

    reg [`DDC_WORD_W-1:0] head_reg;
    reg [`DDC_WORD_W-1:0] tail_reg;
    reg [1:0]             count_reg;
    reg [1:0]             count_next;
    reg                   valid_reg;
    reg                   ready_reg;
    wire                  push;
    wire                  pop;

    assign push        = i_push_valid & ready_reg;
    assign pop         = valid_reg & i_pop_ready;
    assign o_push_ready = ready_reg;
    assign o_pop_valid  = valid_reg;
    assign o_pop_data   = head_reg;

    // occupancy after this cycle
    always @* begin
        count_next = count_reg;
        if (push & ~pop) begin
            count_next = count_reg + 2'd1;
        end else if (pop & ~push) begin
            count_next = count_reg - 2'd1;
        end
    end

    // two entries; flags registered so ports come from flops
    always @(posedge i_clock) begin
        if (i_reset) begin
            head_reg  <= {`DDC_WORD_W{1'b0}};
            tail_reg  <= {`DDC_WORD_W{1'b0}};
            count_reg <= 2'd0;
            valid_reg <= 1'b0;
            ready_reg <= 1'b1;
        end else if (i_clock_enable) begin
            if (push & pop) begin
                if (count_reg == 2'd1) begin
                    head_reg <= i_push_data;
                end else begin
                    head_reg <= tail_reg;
                    tail_reg <= i_push_data;
                end
            end else if (pop) begin
                head_reg <= tail_reg;
            end else if (push) begin
                if (count_reg == 2'd0) begin
                    head_reg <= i_push_data;
                end else begin
                    tail_reg <= i_push_data;
                end
            end
            count_reg <= count_next;
            valid_reg <= (count_next != 2'd0);
            ready_reg <= (count_next != 2'd2);
        end
    end

endmodule

// [rtl/ddc_channel.v]
// Overview of operation
// - tuning word is low byte plus high nibble
// - phase bits 7..0 from phase low byte
// - phase bits 11..8 from phase high nibble
// - mode 00 runs mixer with oscillator
// - mode 01 bypasses mixer, oscillator off
// - mode 10 mixes down by quarter rate
// - mode 11 forces mixer inputs full scale
// - route bits pick channel for i, q
`timescale 1ns/100ps
`include "ddc_regs.vh"

module ddc_channel (
    // clock and control
    input  wire                      i_clock,
    input  wire                      i_reset,
    input  wire                      i_clock_enable,
    // register port
    input  wire [11:0]               i_reg_addr,
    input  wire                      i_reg_write,
    input  wire [7:0]                i_reg_write_data,
    input  wire                      i_reg_read,
    output reg  [7:0]                o_reg_read_data,
    // samples from converter cores
    input  wire                      i_sample_valid,
    input  wire [`DDC_SAMPLE_W-1:0]  i_sample_a,
    input  wire [`DDC_SAMPLE_W-1:0]  i_sample_b,
    output wire                      o_sample_ready,
    // samples towards output framer
    output wire                      o_out_valid,
    output wire [`DDC_WORD_W-1:0]    o_out_data,
    input  wire                      i_out_ready
);

    reg  [7:0]  control_reg;
    reg  [7:0]  route_reg;
    reg  [7:0]  tune_low_reg;
    reg  [3:0]  tune_high_reg;
    reg  [7:0]  phase_low_reg;
    reg  [3:0]  phase_high_reg;
    reg  [11:0] accum_reg;
    reg  [1:0]  quarter_reg;
    reg         keep_reg;

    wire [11:0] tuning_word;
    wire [11:0] phase_offset;
    wire [1:0]  if_mode;
    wire        complex_mix;
    wire        gain_6db;
    wire        to_real;
    wire        dec_by_two;
    wire        accept;
    wire        push;
    wire        buf_ready;

    reg  [11:0] mix_in_i;
    reg  [11:0] mix_in_q;
    reg  [1:0]  cos_code;
    reg  [1:0]  sin_code;
    reg  [13:0] sum_i;
    reg  [13:0] sum_q;
    reg  [11:0] out_i;
    reg  [11:0] out_q;

    // word assembly; upper nibbles never stored
    assign tuning_word  = {tune_high_reg, tune_low_reg};
    assign phase_offset = {phase_high_reg, phase_low_reg};

    // control field decode
    assign complex_mix = control_reg[`DDC_CTL_MIXER_BIT];
    assign gain_6db    = control_reg[`DDC_CTL_GAIN_BIT];
    assign if_mode     = control_reg[`DDC_CTL_IF_HI:`DDC_CTL_IF_LO];
    assign to_real     = control_reg[`DDC_CTL_C2R_BIT];
    assign dec_by_two  = (control_reg[`DDC_CTL_DEC_HI:`DDC_CTL_DEC_LO]
                          == `DDC_DEC_BY_TWO);

    // a sample is taken whenever the buffer can hold it
    assign accept = i_sample_valid & buf_ready;
    assign push   = accept & (keep_reg | ~dec_by_two);
    assign o_sample_ready = buf_ready;

    // sign-extended product of sample and unit code 0, +1, -1
    function [13:0] unit_mul;
        input [11:0] x;
        input [1:0]  c;
        begin
            if (c == 2'b01) begin
                unit_mul = {{2{x[11]}}, x};
            end else if (c == 2'b11) begin
                unit_mul = 14'd0 - {{2{x[11]}}, x};
            end else begin
                unit_mul = 14'd0;
            end
        end
    endfunction

    // clamp to 12 bits after optional 6 dB shift
    function [11:0] clamp;
        input [13:0] v;
        input        g;
        reg   [13:0] s;
        begin
            s = g ? {v[12:0], 1'b0} : v;
            if (~v[13] & ((g & (v[12:11] != 2'b00)) | s[13] | s[12]
                          | s[11])) begin
                clamp = `DDC_FULL_SCALE;
            end else if (v[13] & ((g & (v[12:11] != 2'b11))
                                  | ~s[12] | ~s[11])) begin
                clamp = `DDC_NEG_SCALE;
            end else begin
                clamp = s[11:0];
            end
        end
    endfunction

    // oscillator as coarse quadrant table; keeps logic tiny,
    // trades spectral purity for area
    always @* begin
        mix_in_i = route_pick(route_reg[`DDC_ROUTE_I_BIT],
                              i_sample_a, i_sample_b);
        mix_in_q = route_pick(route_reg[`DDC_ROUTE_Q_BIT],
                              i_sample_a, i_sample_b);
        cos_code = 2'b01;
        sin_code = 2'b00;
        case (if_mode)
            `DDC_IF_QUARTER: begin
                cos_code = quad_cos(quarter_reg);
                sin_code = quad_sin(quarter_reg);
            end
            `DDC_IF_TEST: begin
                mix_in_i = `DDC_FULL_SCALE;
                mix_in_q = `DDC_FULL_SCALE;
                cos_code = quad_cos(accum_reg[11:10]);
                sin_code = quad_sin(accum_reg[11:10]);
            end
            `DDC_IF_VARIABLE: begin
                cos_code = quad_cos(accum_reg[11:10]);
                sin_code = quad_sin(accum_reg[11:10]);
            end
            default: begin
                cos_code = 2'b01;
                sin_code = 2'b00;
            end
        endcase
        if (if_mode == `DDC_IF_ZERO) begin
            sum_i = {{2{mix_in_i[11]}}, mix_in_i};
            sum_q = complex_mix ? {{2{mix_in_q[11]}}, mix_in_q}
                                : 14'd0;
        end else if (complex_mix) begin
            // (i + jq)(cos - j sin)
            sum_i = unit_mul(mix_in_i, cos_code)
                  + unit_mul(mix_in_q, sin_code);
            sum_q = unit_mul(mix_in_q, cos_code)
                  - unit_mul(mix_in_i, sin_code);
        end else begin
            sum_i = unit_mul(mix_in_i, cos_code);
            sum_q = 14'd0 - unit_mul(mix_in_i, sin_code);
        end
        out_i = clamp(sum_i, gain_6db);
        out_q = to_real ? 12'h000 : clamp(sum_q, gain_6db);
    end

    // channel picker, 0 is core a and 1 is core b;
    // samples come in as arguments so always @* sees them change
    function [11:0] route_pick;
        input        sel;
        input [11:0] a;
        input [11:0] b;
        begin
            route_pick = sel ? b : a;
        end
    endfunction

    // quadrant cosine code
    function [1:0] quad_cos;
        input [1:0] q;
        begin
            case (q)
                2'd0:    quad_cos = 2'b01;
                2'd2:    quad_cos = 2'b11;
                default: quad_cos = 2'b00;
            endcase
        end
    endfunction

    // quadrant sine code
    function [1:0] quad_sin;
        input [1:0] q;
        begin
            case (q)
                2'd1:    quad_sin = 2'b01;
                2'd3:    quad_sin = 2'b11;
                default: quad_sin = 2'b00;
            endcase
        end
    endfunction

    // oscillator and quarter-rate sequence advance per sample;
    // zero-if holds the oscillator at its phase offset
    always @(posedge i_clock) begin
        if (i_reset) begin
            accum_reg   <= 12'h000;
            quarter_reg <= 2'd0;
            keep_reg    <= 1'b1;
        end else if (i_clock_enable) begin
            if (if_mode == `DDC_IF_ZERO) begin
                accum_reg <= phase_offset;
            end else if (accept) begin
                accum_reg <= accum_reg + tuning_word;
            end
            if (accept) begin
                quarter_reg <= quarter_reg + 2'd1;
                keep_reg    <= ~keep_reg;
            end
        end
    end

    // register writes, store only defined bits
    always @(posedge i_clock) begin
        if (i_reset) begin
            control_reg    <= `DDC_REG_RESET;
            route_reg      <= `DDC_REG_RESET;
            tune_low_reg   <= `DDC_REG_RESET;
            tune_high_reg  <= 4'h0;
            phase_low_reg  <= `DDC_REG_RESET;
            phase_high_reg <= 4'h0;
        end else if (i_clock_enable & i_reg_write) begin
            if (i_reg_addr == `DDC_CONTROL_ADDR) begin
                control_reg <= i_reg_write_data & `DDC_CTL_MASK;
            end else if (i_reg_addr == `DDC_ROUTE_ADDR) begin
                route_reg <= i_reg_write_data & `DDC_ROUTE_MASK;
            end else if (i_reg_addr == `DDC_TUNE_LOW_ADDR) begin
                tune_low_reg <= i_reg_write_data;
            end else if (i_reg_addr == `DDC_TUNE_HIGH_ADDR) begin
                tune_high_reg <= i_reg_write_data[3:0];
            end else if (i_reg_addr == `DDC_PHASE_LOW_ADDR) begin
                phase_low_reg <= i_reg_write_data;
            end else if (i_reg_addr == `DDC_PHASE_HIGH_ADDR) begin
                phase_high_reg <= i_reg_write_data[3:0];
            end
        end
    end

    // registered read-back; unmapped offsets read zero
    always @(posedge i_clock) begin
        if (i_reset) begin
            o_reg_read_data <= 8'h00;
        end else if (i_clock_enable & i_reg_read) begin
            if (i_reg_addr == `DDC_CONTROL_ADDR) begin
                o_reg_read_data <= control_reg;
            end else if (i_reg_addr == `DDC_ROUTE_ADDR) begin
                o_reg_read_data <= route_reg;
            end else if (i_reg_addr == `DDC_TUNE_LOW_ADDR) begin
                o_reg_read_data <= tune_low_reg;
            end else if (i_reg_addr == `DDC_TUNE_HIGH_ADDR) begin
                o_reg_read_data <= {4'h0, tune_high_reg};
            end else if (i_reg_addr == `DDC_PHASE_LOW_ADDR) begin
                o_reg_read_data <= phase_low_reg;
            end else if (i_reg_addr == `DDC_PHASE_HIGH_ADDR) begin
                o_reg_read_data <= {4'h0, phase_high_reg};
            end else begin
                o_reg_read_data <= 8'h00;
            end
        end
    end

    // two-entry buffer absorbs a framer stall without loss
    ddc_buffer u_buffer (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_push_valid   (push),
        .i_push_data    ({out_i, out_q}),
        .o_push_ready   (buf_ready),
        .o_pop_valid    (o_out_valid),
        .o_pop_data     (o_out_data),
        .i_pop_ready    (i_out_ready)
    );

endmodule

// [tb/ddc_channel_sva.sv]
`timescale 1ns/100ps
module ddc_channel_sva (
    input logic        i_clock,
    input logic        i_reset,
    input logic        i_clock_enable,
    input logic [11:0] i_reg_addr,
    input logic        i_reg_write,
    input logic [7:0]  i_reg_write_data,
    input logic        i_reg_read,
    input logic [7:0]  o_reg_read_data,
    input logic        i_sample_valid,
    input logic [11:0] i_sample_a,
    input logic        o_sample_ready,
    input logic        o_out_valid,
    input logic [23:0] o_out_data,
    input logic        i_out_ready
);
    logic [7:0] m_ctl, m_rte, m_tl, m_th, m_pl, m_ph;
    wire        wr   = i_clock_enable && i_reg_write;
    wire        rd   = i_clock_enable && i_reg_read;
    wire        take = i_clock_enable && i_sample_valid && o_sample_ready;
    wire        room = take && !o_out_valid;
    // masked shadow of each register, so reads can be judged
    always @(posedge i_clock) begin
        if (i_reset) begin
            {m_ctl, m_rte, m_tl, m_th, m_pl, m_ph} <= 48'h0000_0000_0000;
        end else if (wr) begin
            case (i_reg_addr)
                12'h330: m_ctl <= i_reg_write_data & 8'hfb;
                12'h331: m_rte <= i_reg_write_data & 8'h05;
                12'h334: m_tl <= i_reg_write_data;
                12'h335: m_th <= i_reg_write_data & 8'h0f;
                12'h340: m_pl <= i_reg_write_data;
                12'h341: m_ph <= i_reg_write_data & 8'h0f;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    property p_ctl_rd;
        rd && i_reg_addr == 12'h330 |=> o_reg_read_data == $past(m_ctl);
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control readback");
    property p_rte_rd;
        rd && i_reg_addr == 12'h331 |=> o_reg_read_data == $past(m_rte);
    endproperty
    a_rte_rd: assert property (p_rte_rd) else $error("route readback");
    property p_tl_rd;
        rd && i_reg_addr == 12'h334 |=> o_reg_read_data == $past(m_tl);
    endproperty
    a_tl_rd: assert property (p_tl_rd) else $error("tune low readback");
    property p_th_rd;
        rd && i_reg_addr == 12'h335 |=> o_reg_read_data == $past(m_th);
    endproperty
    a_th_rd: assert property (p_th_rd) else $error("tune high readback");
    property p_pl_rd;
        rd && i_reg_addr == 12'h340 |=> o_reg_read_data == $past(m_pl);
    endproperty
    a_pl_rd: assert property (p_pl_rd) else $error("phase low readback");
    property p_ph_rd;
        rd && i_reg_addr == 12'h341 |=> o_reg_read_data == $past(m_ph);
    endproperty
    a_ph_rd: assert property (p_ph_rd) else $error("phase high readback");
    property p_zero_if;
        room && m_ctl == 8'h90 && m_rte == 8'h00 |=> o_out_valid
            && o_out_data == {$past(i_sample_a), $past(i_sample_a)};
    endproperty
    a_zero_if: assert property (p_zero_if) else $error("zero if pass");
    property p_c2r;
        room && m_ctl[3] && m_ctl[1:0] != 2'b10 |=> o_out_valid
            && o_out_data[11:0] == 12'h000;
    endproperty
    a_c2r: assert property (p_c2r) else $error("complex to real");
    property p_test;
        room && (m_ctl & 8'hfa) == 8'h30 |=> o_out_valid
            && (o_out_data[23:12] | o_out_data[11:0]) inside {12'h7ff, 12'h801}
            && (o_out_data[23:12] == 12'h000 || o_out_data[11:0] == 12'h000);
    endproperty
    a_test: assert property (p_test) else $error("test mode level");
    // a stalled word must not move or vanish
    property p_hold;
        o_out_valid && !i_out_ready && i_clock_enable |=> o_out_valid
            && $stable(o_out_data);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled word changed");
    c_full: cover property (o_out_valid && !o_sample_ready);
    c_test: cover property (room && m_ctl[5:4] == 2'b11);
    c_c2r: cover property (room && m_ctl[3]);
endmodule

bind ddc_channel ddc_channel_sva chk_u (
    .i_clock(i_clock), .i_reset(i_reset), .i_clock_enable(i_clock_enable),
    .i_reg_addr(i_reg_addr), .i_reg_write(i_reg_write),
    .i_reg_write_data(i_reg_write_data), .i_reg_read(i_reg_read),
    .o_reg_read_data(o_reg_read_data), .i_sample_valid(i_sample_valid),
    .i_sample_a(i_sample_a), .o_sample_ready(o_sample_ready),
    .o_out_valid(o_out_valid), .o_out_data(o_out_data),
    .i_out_ready(i_out_ready)
);

// [tb/ddc_framer_model.sv]
`timescale 1ns/100ps
module ddc_framer_model (
    input  logic        i_clock,
    input  logic        i_stall,
    input  logic        i_valid,
    input  logic [23:0] i_data,
    output logic        o_ready
);
    logic [23:0] got [$];
    // ready moves just after the edge so the design sees it settled
    always @(posedge i_clock) o_ready <= !i_stall;
    // a word counts only where valid and ready meet
    always @(posedge i_clock) if (i_valid && o_ready) got.push_back(i_data);
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
    logic        i_clock, i_reset, i_clock_enable, i_reg_write, i_reg_read;
    logic [11:0] i_reg_addr, i_sample_a, i_sample_b;
    logic [7:0]  i_reg_write_data;
    logic        i_sample_valid, stall;
    wire  [7:0]  o_reg_read_data;
    wire         o_sample_ready, o_out_valid, i_out_ready;
    wire  [23:0] o_out_data;
    int          n_mismatch = 0;
    int          check_count = 0;
    logic [23:0] w [0:3];
    logic [11:0] ra [0:5] = '{12'h330, 12'h331, 12'h334, 12'h335, 12'h340,
                              12'h341};
    logic [7:0]  rm [0:5] = '{8'hfb, 8'h05, 8'hff, 8'h0f, 8'hff, 8'h0f};

    ddc_channel dut_u (
        .i_clock(i_clock), .i_reset(i_reset), .i_clock_enable(i_clock_enable),
        .i_reg_addr(i_reg_addr), .i_reg_write(i_reg_write),
        .i_reg_write_data(i_reg_write_data), .i_reg_read(i_reg_read),
        .o_reg_read_data(o_reg_read_data), .i_sample_valid(i_sample_valid),
        .i_sample_a(i_sample_a), .i_sample_b(i_sample_b),
        .o_sample_ready(o_sample_ready), .o_out_valid(o_out_valid),
        .o_out_data(o_out_data), .i_out_ready(i_out_ready)
    );
    ddc_framer_model fm_u (
        .i_clock(i_clock), .i_stall(stall), .i_valid(o_out_valid),
        .i_data(o_out_data), .o_ready(i_out_ready)
    );

    task chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge i_clock);
        {i_reg_addr, i_reg_write_data, i_reg_write} = {a, d, 1'b1};
        @(negedge i_clock);
        i_reg_write = 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge i_clock);
        {i_reg_addr, i_reg_read} = {a, 1'b1};
        @(negedge i_clock);
        i_reg_read = 1'b0;
        chk({16'h0, o_reg_read_data}, {16'h0, e});
    endtask
    // valid stays up until ready is seen at a rising edge
    task push(input logic [11:0] a, input logic [11:0] b);
        @(negedge i_clock);
        {i_sample_valid, i_sample_a, i_sample_b} = {1'b1, a, b};
        for (int k = 0; k < 40 && o_sample_ready !== 1'b1; k++)
            @(negedge i_clock);
        @(posedge i_clock);
    endtask
    // released sample lines carry junk, never the last value
    task idle;
        @(negedge i_clock);
        i_sample_valid = 1'b0;
        {i_sample_a, i_sample_b} = ~{i_sample_a, i_sample_b};
    endtask
    task get(output logic [23:0] x);
        for (int k = 0; k < 40 && fm_u.got.size() == 0; k++)
            @(negedge i_clock);
        x = fm_u.got.size() ? fm_u.got.pop_front() : 'x;
    endtask
    task one(input logic [11:0] a, b, input logic [23:0] e);
        push(a, b);
        idle;
        get(w[0]);
        chk(w[0], e);
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    // generous bound; the sequence needs well under a thousand cycles
    initial begin
        repeat (6000) @(posedge i_clock);
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude;
    end
    initial begin
        {i_reset, i_clock_enable, stall} = 3'b110;
        {i_reg_write, i_reg_read, i_sample_valid} = 3'b000;
        {i_reg_addr, i_sample_a, i_sample_b, i_reg_write_data} = 44'h0;
        repeat (10) @(negedge i_clock);
        i_reset = 1'b0;
        for (int k = 0; k < 6; k++) rd(ra[k], 8'h00);
        for (int k = 0; k < 6; k++) begin
            wr(ra[k], 8'hff);
            rd(ra[k], rm[k]);
        end
        wr(12'h332, 8'hff);
        rd(12'h332, 8'h00);
        i_clock_enable = 1'b0;
        wr(12'h334, 8'h12);
        i_clock_enable = 1'b1;
        rd(12'h334, 8'hff);
        $display("test done: registers");
        wr(12'h330, 8'h90);
        wr(12'h334, 8'h00);
        wr(12'h335, 8'h00);
        wr(12'h340, 8'ha5);
        wr(12'h341, 8'hf8);
        wr(12'h331, 8'h01);
        one(12'h123, 12'h456, {12'h456, 12'h123});
        wr(12'h331, 8'h04);
        one(12'h123, 12'h456, {12'h123, 12'h456});
        wr(12'h330, 8'hd0);
        one(12'h500, 12'h100, {12'h7ff, 12'h200});
        one(12'ha00, 12'hf00, {12'h800, 12'he00});
        wr(12'h330, 8'h98);
        one(12'h321, 12'h654, {12'h321, 12'h000});
        $display("test done: zero if, gain, complex to real");
        // accumulator still holds the phase loaded in zero if mode
        wr(12'h330, 8'h00);
        one(12'h100, 12'h055, {12'hf00, 12'h000});
        wr(12'h335, 8'hf8);
        push(12'h100, 12'h0);
        push(12'h100, 12'h0);
        idle;
        get(w[0]);
        get(w[1]);
        chk({w[0][23:12] + w[1][23:12], w[0][11:0] | w[1][11:0]}, 24'h0);
        chk({23'h0, w[0][23:12] inside {12'h100, 12'hf00}}, 24'h1);
        $display("test done: variable if");
        wr(12'h330, 8'h20);
        for (int k = 0; k < 4; k++) push(12'h100, 12'h0);
        idle;
        for (int k = 0; k < 4; k++) get(w[k]);
        chk({w[0][23:12] + w[2][23:12], w[1][23:12] + w[3][23:12]}, 0);
        chk({w[0][11:0] + w[2][11:0], w[1][11:0] + w[3][11:0]}, 0);
        chk({22'h0, (w[0][23:12] == 0) != (w[1][23:12] == 0),
             (w[0][23:12] == 0) != (w[0][11:0] == 0)}, 24'h3);
        wr(12'h330, 8'h30);
        push(12'h123, 12'h0);
        idle;
        get(w[0]);
        chk({23'h0, (w[0][23:12] | w[0][11:0]) inside {12'h7ff, 12'h801}},
            24'h1);
        $display("test done: quarter rate and test mode");
        wr(12'h330, 8'h92);
        for (int k = 0; k < 4; k++) push(12'(k + 1), 12'h0);
        idle;
        get(w[0]);
        get(w[1]);
        repeat (6) @(negedge i_clock);
        chk({12'h0, w[1][23:12] - w[0][23:12]}, 24'h2);
        chk(24'(fm_u.got.size()), 24'h0);
        $display("test done: decimation");
        wr(12'h330, 8'h90);
        wr(12'h331, 8'h00);
        stall = 1'b1;
        fork
            for (int k = 0; k < 4; k++) push(12'(16 + k), 12'(16 + k));
            begin
                repeat (12) @(negedge i_clock);
                chk({23'h0, o_sample_ready}, 24'h0);
                stall = 1'b0;
            end
        join
        idle;
        for (int k = 0; k < 4; k++) begin
            get(w[0]);
            chk(w[0], {12'(16 + k), 12'(16 + k)});
        end
        $display("test done: buffer stall");
        // complex mix, oscillator parked in the cosine -1 quadrant
        wr(12'h330, 8'h80);
        one(12'h100, 12'h040, {12'hf00, 12'hf00});
        $display("test done: complex mixer");
        conclude;
    end
endmodule
